// file: rtl/led_channel_fault_manager.sv
// led channel fault manager: channel supervision, thermal and uv shutdown
//
// What this block does
// - channel above short threshold, no thermal flag: off after six pwm
// - shorted channel below threshold stays enabled, no fault action
// - channel at target is good; good channel losing target is open
// - at overvoltage limit, every channel not yet good is open at once
// - open channel is disabled only after a six pwm cycle timeout
// - at overvoltage, channels below target turn off after six pwm cycles
// - regulation feedback uses active channels at target, or all active channels if none is
// - one channel's disable leaves the others' enable and dimming alone
// - fault classification waits until feedback shows stable operation
// - over-temperature stops boost and sinks, latched until undervoltage
// - undervoltage lockout stops boost, resets all state until it clears
`timescale 1ns/1ps
`default_nettype none
module led_channel_fault_manager
    import led_fault_pkg::*;
#(
    parameter int unsigned NUM_CH    = NUM_CH_DEF,
    parameter int unsigned SETTLE_PWM = SETTLE_PWM_DEF
) (
    // clock and reset
    input  wire logic              I_REF_CLK,
    input  wire logic              I_NRST,
    // dimming and loop status
    input  wire logic              I_PWM_TICK,     // one per pwm cycle
    input  wire logic              I_LOOP_STEADY,  // led feedback settled
    // chip-level flags
    input  wire logic              I_OUTPUT_OVERVOLTAGE_FLAG,
    input  wire logic              I_OVER_TEMP,
    input  wire logic              I_INPUT_UNDERVOLTAGE_LOCKOUT,
    // per-channel comparators
    input  wire logic [NUM_CH-1:0] I_SHORT_FAULT_DETECT,
    input  wire logic [NUM_CH-1:0] I_AT_TARGET,
    // outputs
    output logic                   O_BOOST_EN,
    output logic      [NUM_CH-1:0] O_SINK_EN,
    output logic      [NUM_CH-1:0] O_FB_SEL,
    output logic      [NUM_CH-1:0] O_CH_GOOD,
    output logic      [NUM_CH-1:0] O_OPEN_FAULT_DETECT,
    output logic                   O_THERMAL_SHUTDOWN
);

    localparam int unsigned SW = $clog2(SETTLE_PWM + 1);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // blank a channel vector while the thermal latch holds
    function automatic logic [NUM_CH-1:0] gate_hot(
        input logic              hot,
        input logic [NUM_CH-1:0] vec
    );
        return hot ? '0 : vec;
    endfunction

    // ---------------------------------------------------------------
    // internal reset: pin reset or undervoltage lockout
    // ---------------------------------------------------------------
    logic uv_rst_n;
    assign uv_rst_n = I_NRST && !I_INPUT_UNDERVOLTAGE_LOCKOUT;

    // ---------------------------------------------------------------
    // loop stability qualifier: steady for SETTLE_PWM pwm cycles
    // ---------------------------------------------------------------
    logic [SW-1:0] settle_reg, settle_next;
    logic          stable;

    // count pwm ticks while the loop reports steady
    always_comb begin
        settle_next = settle_reg;
        if (!I_LOOP_STEADY) begin
            settle_next = '0;
        end else if (I_PWM_TICK && settle_reg != SW'(SETTLE_PWM)) begin
            settle_next = settle_reg + SW'(1);
        end
    end

    // settle counter register
    always_ff @(posedge I_REF_CLK or negedge uv_rst_n) begin
        if (!uv_rst_n) begin
            settle_reg <= '0;
        end else begin
            settle_reg <= settle_next;
        end
    end

    // faults qualify only once the loop has stayed steady long enough
    assign stable = I_LOOP_STEADY
                    && (settle_reg == SW'(SETTLE_PWM));

    // ---------------------------------------------------------------
    // thermal latch, cleared only through the undervoltage reset
    // ---------------------------------------------------------------
    logic otp_reg, otp_next;

    // set on any over-temperature sample, never cleared here
    always_comb begin
        otp_next = otp_reg || I_OVER_TEMP;
    end

    // latch register, reset only by pin reset or undervoltage
    always_ff @(posedge I_REF_CLK or negedge uv_rst_n) begin
        if (!uv_rst_n) begin
            otp_reg <= 1'b0;
        end else begin
            otp_reg <= otp_next;
        end
    end

    // ---------------------------------------------------------------
    // channel supervisors, independent so one fault spares the rest
    // ---------------------------------------------------------------
    logic [NUM_CH-1:0] ch_en, ch_good, ch_open;

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        chan_sense_s s;
        // bundle this channel's two comparator bits
        assign s = '{above_short: I_SHORT_FAULT_DETECT[g],
                     at_target:   I_AT_TARGET[g]};
        led_chan_qual u_qual (
            .clk        (I_REF_CLK),
            .rst_n      (uv_rst_n),
            .pwm_tick   (I_PWM_TICK),
            .stable     (stable),
            .output_overvoltage_flag        (I_OUTPUT_OVERVOLTAGE_FLAG),
            .otp_hold   (otp_reg),
            .sense      (s),
            .enabled    (ch_en[g]),
            .good       (ch_good[g]),
            .open_flag  (ch_open[g]),
            .short_flag ()               // short state stays internal
        );
    end

    // ---------------------------------------------------------------
    // boost and thermal outputs
    // ---------------------------------------------------------------
    logic boost_next, therm_next;

    // boost may switch only while no thermal shutdown is latched
    always_comb begin
        therm_next = otp_next;
        boost_next = !otp_next;
    end

    // boost enable and thermal flag registers
    always_ff @(posedge I_REF_CLK or negedge uv_rst_n) begin
        if (!uv_rst_n) begin
            O_BOOST_EN         <= 1'b0;
            O_THERMAL_SHUTDOWN <= 1'b0;
        end else begin
            O_BOOST_EN         <= boost_next;
            O_THERMAL_SHUTDOWN <= therm_next;
        end
    end

    // ---------------------------------------------------------------
    // current sink enables
    // ---------------------------------------------------------------
    logic [NUM_CH-1:0] sink_next;

    // each sink follows its own supervisor; heat turns all of them off
    always_comb begin
        sink_next = gate_hot(otp_next, ch_en);
    end

    // sink enable register, all sinks off in reset
    always_ff @(posedge I_REF_CLK or negedge uv_rst_n) begin
        if (!uv_rst_n) begin
            O_SINK_EN <= '0;
        end else begin
            O_SINK_EN <= sink_next;
        end
    end

    // ---------------------------------------------------------------
    // regulation feedback selection
    // ---------------------------------------------------------------
    logic [NUM_CH-1:0] fb_live, fb_next;

    // feedback from active channels at target; while none is at target,
    // all active channels steer the loop so the boost can ramp
    always_comb begin
        fb_live = ch_en & I_AT_TARGET;
        if (fb_live == '0) begin
            fb_live = ch_en;
        end
        fb_next = gate_hot(otp_next, fb_live);
    end

    // feedback select register
    always_ff @(posedge I_REF_CLK or negedge uv_rst_n) begin
        if (!uv_rst_n) begin
            O_FB_SEL <= '0;
        end else begin
            O_FB_SEL <= fb_next;
        end
    end

    // ---------------------------------------------------------------
    // channel status outputs
    // ---------------------------------------------------------------
    logic [NUM_CH-1:0] good_next, open_next;

    // good and open flags straight from the supervisors
    always_comb begin
        good_next = ch_good;
        open_next = ch_open;
    end

    // status registers
    always_ff @(posedge I_REF_CLK or negedge uv_rst_n) begin
        if (!uv_rst_n) begin
            O_CH_GOOD           <= '0;
            O_OPEN_FAULT_DETECT <= '0;
        end else begin
            O_CH_GOOD           <= good_next;
            O_OPEN_FAULT_DETECT <= open_next;
        end
    end

endmodule : led_channel_fault_manager
`default_nettype wire

// file: rtl/led_fault_pkg.sv
// constants and carrier types for the led channel fault manager
package led_fault_pkg;

    // ---------------------------------------------------------------
    // timing and sizing
    // ---------------------------------------------------------------
    localparam int unsigned FAULT_TIMEOUT_PWM = 6;   // pwm cycles to disable
    localparam int unsigned CNT_W             = 3;   // timeout counter width
    localparam int unsigned NUM_CH_DEF        = 6;   // default channel count
    localparam int unsigned SETTLE_PWM_DEF    = 2;   // stable pwm cycles
    localparam logic [CNT_W-1:0] CNT_RESET    = 3'h0;

    // ---------------------------------------------------------------
    // per-channel comparator inputs, sampled each clock
    // ---------------------------------------------------------------
    typedef struct packed {
        logic above_short;   // channel voltage over the short threshold
        logic at_target;     // channel current at programmed target
    } chan_sense_s;

    // ---------------------------------------------------------------
    // per-channel qualification state
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        CH_IDLE     = 4'h1,  // enabled, not yet good
        CH_GOOD     = 4'h2,  // reached target
        CH_OPEN     = 4'h4,  // classified open, timing out
        CH_DISABLED = 4'h8   // switched off for a fault
    } chan_state_e;

endpackage : led_fault_pkg

// file: rtl/led_chan_qual.sv
// one channel: good/open qualification, short detection and timeout
`timescale 1ns/1ps
`default_nettype none
module led_chan_qual
    import led_fault_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // control
    input  wire logic        pwm_tick,    // one pulse per dimming pwm cycle
    input  wire logic        stable,      // loop settled, faults qualify
    input  wire logic        output_overvoltage_flag,         // output at overvoltage limit
    input  wire logic        otp_hold,    // thermal shutdown latched
    input  wire chan_sense_s sense,
    // status
    output logic             enabled,
    output logic             good,
    output logic             open_flag,
    output logic             short_flag
);

    chan_state_e      state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic             short_reg, short_next;
    logic             fault_now;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        short_next = short_reg;
        // shorts only count with no thermal flag and a settled loop
        short_next = sense.above_short && !otp_hold && stable;
        case (state_reg)
            CH_IDLE: begin
                if (sense.at_target) begin
                    state_next = CH_GOOD;
                end else if (output_overvoltage_flag && stable) begin
                    state_next = CH_OPEN;
                end
            end
            CH_GOOD: begin
                if (!sense.at_target && stable) begin
                    state_next = CH_OPEN;
                end
            end
            CH_OPEN: begin
                // condition gone: back to good if at target, else idle; a timeout expiring on the same tick disables instead
                if (sense.at_target || !stable) begin
                    state_next = sense.at_target ? CH_GOOD : CH_IDLE;
                end
            end
            CH_DISABLED: begin
                state_next = CH_DISABLED;   // only reset reenables
            end
            default: begin
                state_next = CH_IDLE;
            end
        endcase
        // timeout counts pwm cycles while open or shorted
        fault_now = (state_reg == CH_OPEN) || short_reg;
        if (state_reg == CH_DISABLED) begin
            cnt_next = CNT_RESET;
        end else if (!fault_now || !stable) begin
            cnt_next = CNT_RESET;
        end else if (pwm_tick) begin
            if (cnt_reg == CNT_W'(FAULT_TIMEOUT_PWM - 1)) begin
                state_next = CH_DISABLED;
                cnt_next   = CNT_RESET;
            end else begin
                cnt_next = cnt_reg + CNT_W'(1);
            end
        end
        // a short below threshold takes no action at all
        if (!short_reg && state_reg != CH_OPEN
            && state_reg != CH_DISABLED) begin
            cnt_next = CNT_RESET;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= CH_IDLE;
            cnt_reg   <= CNT_RESET;
            short_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            short_reg <= short_next;
        end
    end

    // ---------------------------------------------------------------
    // status
    // ---------------------------------------------------------------
    assign enabled    = (state_reg != CH_DISABLED);
    assign good       = (state_reg == CH_GOOD);
    assign open_flag  = (state_reg == CH_OPEN);
    assign short_flag = short_reg;

endmodule : led_chan_qual
`default_nettype wire

// file: verification/led_fault_sva.sv
// concurrent checks on the led channel fault manager ports
`timescale 1ns/1ps
`default_nettype none
module led_fault_sva
    import led_fault_pkg::*;
#(
    parameter int unsigned NUM_CH = NUM_CH_DEF
) (
    // clock, reset and flags
    input wire logic              I_REF_CLK,
    input wire logic              I_NRST,
    input wire logic              I_LOOP_STEADY,
    input wire logic              I_OVER_TEMP,
    input wire logic              I_INPUT_UNDERVOLTAGE_LOCKOUT,
    // watched outputs
    input wire logic              O_BOOST_EN,
    input wire logic [NUM_CH-1:0] O_SINK_EN,
    input wire logic [NUM_CH-1:0] O_FB_SEL,
    input wire logic              O_THERMAL_SHUTDOWN
);
    // -----------------------------------------------------------
    // properties
    // -----------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_NRST || I_INPUT_UNDERVOLTAGE_LOCKOUT);
    sequence unsteady_run;
        !I_LOOP_STEADY [*4];
    endsequence
    sequence heat_seen;
        I_OVER_TEMP;
    endsequence
    a_input_undervoltage_lockout_all_off: assert property (disable iff (!I_NRST)
        I_INPUT_UNDERVOLTAGE_LOCKOUT |-> !O_BOOST_EN && O_SINK_EN == '0)
        else $error("outputs live during undervoltage");
    a_heat_stops_all: assert property (
        heat_seen |=> O_THERMAL_SHUTDOWN && !O_BOOST_EN && O_SINK_EN == '0)
        else $error("over-temperature did not shut down");
    a_heat_latched: assert property (
        O_THERMAL_SHUTDOWN |=> O_THERMAL_SHUTDOWN && !O_BOOST_EN)
        else $error("thermal latch released");
    a_latch_sinks_off: assert property (
        O_THERMAL_SHUTDOWN |-> O_SINK_EN == '0 && O_FB_SEL == '0)
        else $error("sink on while thermal latched");
    a_sink_no_rise: assert property (
        $past(O_BOOST_EN) |-> (O_SINK_EN & ~$past(O_SINK_EN)) == '0)
        else $error("disabled sink came back");
    a_fb_active_only: assert property (
        (O_FB_SEL & ~O_SINK_EN) == '0)
        else $error("feedback from disabled channel");
    a_unsteady_hold: assert property (
        unsteady_run ##0 (!O_THERMAL_SHUTDOWN && !I_OVER_TEMP)
        |=> (O_SINK_EN | ~$past(O_SINK_EN)) == '1)
        else $error("sink dropped while unsteady");
    a_boost_resumes: assert property (
        !I_OVER_TEMP && !O_THERMAL_SHUTDOWN |=> O_BOOST_EN)
        else $error("boost off without cause");
endmodule // led_fault_sva
bind led_channel_fault_manager led_fault_sva #(.NUM_CH(NUM_CH)) u_sva (
    .I_REF_CLK, .I_NRST, .I_LOOP_STEADY, .I_OVER_TEMP,
    .I_INPUT_UNDERVOLTAGE_LOCKOUT, .O_BOOST_EN, .O_SINK_EN, .O_FB_SEL,
    .O_THERMAL_SHUTDOWN);
`default_nettype wire

// file: verification/string_model.sv
// comparator and led string model facing the fault manager
`timescale 1ns/1ps
`default_nettype none
module string_model #(
    parameter int unsigned NUM_CH = 6,
    parameter int unsigned LAG    = 2
) (
    // clock
    input  wire logic              clk,
    // commands and sink state
    input  wire logic [NUM_CH-1:0] sink_en,
    input  wire logic [NUM_CH-1:0] short_cmd,
    input  wire logic [NUM_CH-1:0] open_cmd,
    // comparator outputs
    output logic      [NUM_CH-1:0] above_short = '0,
    output logic      [NUM_CH-1:0] at_target   = '0
);
    int cnt [NUM_CH];
    // current settles LAG+1 cycles after a healthy sink turns on
    always @(posedge clk) begin
        for (int g = 0; g < NUM_CH; g++) begin
            cnt[g] <= (sink_en[g] && !open_cmd[g]) ? cnt[g] + 1 : 0;
            at_target[g] <= sink_en[g] && !open_cmd[g] && cnt[g] >= LAG;
        end
        above_short <= short_cmd;
    end
endmodule // string_model
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the led channel fault manager
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int NCH = 6;
    logic clk = 1'b0, nrst = 1'b0, tick = 1'b0, steady = 1'b1;
    logic output_overvoltage_flag = 1'b0, otp = 1'b0, input_undervoltage_lockout = 1'b0, boost, therm;
    logic [NCH-1:0] short_cmd = '0, open_cmd = '0, sc, at, sink, fb;
    logic [NCH-1:0] good, open_f, live = '1;
    logic [3:0] tcnt = 4'h0;
    int mismatches = 0;
    int num_checks = 0;
    always #25 clk = ~clk;
    // one dimming tick every 16 clocks
    always @(posedge clk) begin
        tcnt <= tcnt + 4'h1;
        tick <= (tcnt == 4'h7);
    end
    string_model #(.NUM_CH(NCH), .LAG(3)) model (.clk(clk), .sink_en(sink),
        .short_cmd(short_cmd), .open_cmd(open_cmd), .above_short(sc),
        .at_target(at));
    led_channel_fault_manager #(.NUM_CH(NCH), .SETTLE_PWM(1)) dut (
        .I_REF_CLK(clk), .I_NRST(nrst), .I_PWM_TICK(tick),
        .I_LOOP_STEADY(steady), .I_OUTPUT_OVERVOLTAGE_FLAG(output_overvoltage_flag),
        .I_OVER_TEMP(otp), .I_INPUT_UNDERVOLTAGE_LOCKOUT(input_undervoltage_lockout),
        .I_SHORT_FAULT_DETECT(sc), .I_AT_TARGET(at), .O_BOOST_EN(boost),
        .O_SINK_EN(sink), .O_FB_SEL(fb), .O_CH_GOOD(good),
        .O_OPEN_FAULT_DETECT(open_f), .O_THERMAL_SHUTDOWN(therm));
    // -----------------------------------------------------------
    // helpers
    // -----------------------------------------------------------
    task automatic chk(input string what, input logic [NCH-1:0] exp,
                       input logic [NCH-1:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wait_ticks(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (tick !== 1'b1 && k < 40);
            if (k >= 40) begin
                mismatches++;
                final_report();
            end
        end
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        short_cmd <= '0;
        open_cmd <= '0;
        cycles(8);
        nrst <= 1'b1;
        live = '1;
    endtask
    // on before the sixth tick, off after it, others untouched
    task automatic expect_timeout(input int ch);
        wait_ticks(5);
        cycles(2);
        chk("sink early", live, sink);
        wait_ticks(1);
        cycles(2);
        live[ch] = 1'b0;
        chk("sink late", live, sink);
    endtask
    // -----------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------
    task automatic t_start();
        wait_ticks(3);
        cycles(2);
        chk("boost", 6'h01, 6'(boost));
        chk("good", '1, good);
        $display("test start done");
    endtask
    task automatic t_short();
        short_cmd[1] <= 1'b1;
        wait_ticks(3);
        short_cmd[1] <= 1'b0;
        wait_ticks(6);
        cycles(2);
        chk("sink abort", live, sink);
        short_cmd[1] <= 1'b1;
        expect_timeout(1);
        short_cmd[1] <= 1'b0;
        $display("test short done");
    endtask
    task automatic t_open();
        wait_ticks(1);
        open_cmd[3] <= 1'b1;
        cycles(6);
        chk("open flag", 6'h08, open_f);
        expect_timeout(3);
        chk("fb", live, fb);
        $display("test open done");
    endtask
    task automatic t_unsteady();
        steady <= 1'b0;
        short_cmd[0] <= 1'b1;
        wait_ticks(8);
        cycles(2);
        chk("sink unsteady", live, sink);
        short_cmd[0] <= 1'b0;
        steady <= 1'b1;
        wait_ticks(2);
        $display("test unsteady done");
    endtask
    task automatic t_ovp();
        do_reset();
        open_cmd[4] <= 1'b1;
        wait_ticks(3);
        output_overvoltage_flag <= 1'b1;
        cycles(5);
        chk("ovp open", 6'h10, open_f);
        expect_timeout(4);
        output_overvoltage_flag <= 1'b0;
        cycles(3);
        chk("good", 6'h2F, good);
        chk("fb ovp", 6'h2F, fb);
        $display("test ovp done");
    endtask
    task automatic t_temp();
        otp <= 1'b1;
        cycles(1);
        otp <= 1'b0;
        cycles(2);
        chk("therm", 6'h01, 6'(therm));
        cycles(20);
        chk("boost", 6'h00, 6'(boost));
        chk("sink", '0, sink);
        input_undervoltage_lockout <= 1'b1;
        cycles(2);
        input_undervoltage_lockout <= 1'b0;
        cycles(2);
        chk("therm", 6'h00, 6'(therm));
        chk("sink", '1, sink);
        $display("test temp done");
    endtask
    initial begin
        do_reset();
        t_start();
        t_short();
        t_open();
        t_unsteady();
        t_ovp();
        t_temp();
        final_report();
    end
endmodule // testbench
`default_nettype wire
